// *** src/first_set_finder.sv ***
// lowest set bit finder for register masks
`timescale 1ns/10ps

module first_set_finder
#(
   parameter int WIDTH = 16,
   parameter int IDX_W = 4
)
(
   // mask in
   input  wire logic [WIDTH-1:0] vec,
   // result
   output logic                  found,
   output logic [IDX_W-1:0]      index
);

   always_comb
   begin
      found = 1'b0;
      index = '0;
      // downward walk so the lowest set bit is the last to land
      for (int i = WIDTH - 1; i >= 0; i--)
      begin
         if (vec[i])
         begin
            found = 1'b1;
            index = IDX_W'(i);
         end
      end
   end

endmodule

// *** src/move_exec_cfg.svh ***
// constants for the move group executor
`ifndef MOVE_EXEC_CFG_SVH
`define MOVE_EXEC_CFG_SVH

// ------------------------------------------------------------
// operation word patterns
// ------------------------------------------------------------
`define OPC_QUICK      4'h7
`define OPC_ZERO       4'h0
`define OPC_SPACE      8'h0E
`define OPC_MULTI      5'h09
`define MULTI_MID      3'h1
`define PER_MODE       3'h1

// ------------------------------------------------------------
// effective address modes
// ------------------------------------------------------------
`define EA_IND         3'h2
`define EA_POST        3'h3
`define EA_PRE         3'h4
`define EA_DISP        3'h5
`define EA_IDX         3'h6
`define EA_EXT         3'h7
`define EAX_ABSW       3'h0
`define EAX_ABSL       3'h1
`define EAX_PCD        3'h2
`define EAX_PCX        3'h3

// ------------------------------------------------------------
// sizes, lengths, exceptions
// ------------------------------------------------------------
`define SZ_BYTE        2'h0
`define SZ_WORD        2'h1
`define SZ_LONG        2'h2
`define SZ_BAD         2'h3
`define LEN_BYTE       32'h1
`define LEN_WORD       32'h2
`define LEN_LONG       32'h4
`define PER_STEP       32'h2
`define PER_CNT_WORD   3'h2
`define PER_CNT_LONG   3'h4
`define PER_TOP_WORD   2'h1
`define PER_TOP_LONG   2'h3
`define SPACE_CNT      3'h1
`define EXC_NONE       2'h0
`define EXC_ILLEGAL    2'h1
`define EXC_PRIV       2'h2

// ------------------------------------------------------------
// register port map and fields
// ------------------------------------------------------------
`define REG_CTRL       5'h10
`define REG_SFC        5'h11
`define REG_DFC        5'h12
`define REG_STAT       5'h13
`define CTRL_SUPER     13
`define CCR_MSB        4
`define STAT_BUSY      0
`define STAT_EXC_LSB   1
`define SUPER_RESET    1'b1
`define SPACE_RESET    3'h0

`endif

// *** src/move_exec_pkg.sv ***
// types shared by the move group executor
package move_exec_pkg;

   typedef enum logic [1:0]
   {
      ST_IDLE = 2'h0,
      ST_BUS  = 2'h1,
      ST_DONE = 2'h3,
      ST_TRAP = 2'h2
   } exec_state_type;

   typedef enum logic [1:0]
   {
      K_MULTI  = 2'h0,
      K_PERIPH = 2'h1,
      K_SPACE  = 2'h2
   } op_kind_type;

   typedef struct packed
   {
      logic [15:0] op;
      logic [15:0] ext;
      logic [31:0] ea;
   } instr_type;

   typedef struct packed
   {
      logic        req;
      logic        write;
      logic [1:0]  size;
      logic        lowLane;
      logic [2:0]  space;
      logic [31:0] addr;
      logic [31:0] wdata;
   } mem_req_type;

   typedef struct packed
   {
      logic x;
      logic n;
      logic z;
      logic v;
      logic c;
   } ccr_type;

   typedef struct packed
   {
      op_kind_type kind;
      logic        write;
      logic [1:0]  size;
      logic [31:0] len;
      logic        pre;
      logic        wb;
      logic [3:0]  wbReg;
      logic [31:0] addr;
      logic [15:0] mask;
      logic [2:0]  cnt;
      logic [1:0]  byteIdx;
      logic [3:0]  curReg;
      logic        areg;
      logic        extra;
   } exec_ctx_type;

endpackage

// *** src/move_group_exec.sv ***
// executor for the multi-register, peripheral, quick and alternate-space moves
`timescale 1ns/10ps
`include "move_exec_cfg.svh"

// Notes on behaviour
// - multi move load accepts control modes and postincrement only.
// - normal mask order: bit 0 is D0 first, bit 15 is A7 last.
// - predecrement mask reversed: bit 0 is A7, bit 15 is D0.
// - multi move load ends with one extra read just above the last image.
// - peripheral move steps the address by two per byte.
// - peripheral move sends the most significant byte first, least last.
// - peripheral address is address register plus signed 16-bit displacement.
// - even start uses upper data byte lane, odd start the lower lane.
// - peripheral opmode 100/101 load word/long, 110/111 store word/long.
// - quick load sign-extends the 8-bit immediate into a whole data register.
// - quick load sets N and Z, clears V and C, keeps X.
// - alternate-space move traps on privilege when in user state.
// - alternate-space stores use destination code, loads use source code.
// - space load: data register keeps upper bits, address register sign-extends.
// - space size field 00 byte, 01 word, 10 long.
// - space move accepts only memory alterable addressing modes.
// - space extension: type bit picks data/address, direction bit picks store.
// - control-mode multi moves start at the address and step by length.
// - multi move direction bit 0 stores registers, 1 loads them.
module move_group_exec
#(
   parameter logic [2:0] USER_SPACE  = 3'h1,
   parameter logic [2:0] SUPER_SPACE = 3'h5
)
(
   // clock and reset
   input  wire logic                     clk,
   input  wire logic                     nrst,
   // instruction hand-off
   input  wire logic                     instrValid,
   input  wire move_exec_pkg::instr_type instrIn,
   output logic                          instrReady,
   output logic                          doneOut,
   output logic [1:0]                    excOut,
   // register port
   input  wire logic [4:0]               regAddr,
   input  wire logic [31:0]              regWdata,
   input  wire logic                     regWr,
   input  wire logic                     regRd,
   output logic [31:0]                   regRdata,
   // memory bus
   output move_exec_pkg::mem_req_type    memOut,
   input  wire logic                     memAck,
   input  wire logic [31:0]              memRdata
);
   import move_exec_pkg::*;

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic [31:0]    gpr_q [0:15];
   exec_state_type state_q;
   exec_state_type state_d;
   exec_ctx_type   ctx_q;
   exec_ctx_type   ctx_d;
   mem_req_type    mem_q;
   mem_req_type    mem_d;
   ccr_type        ccr_q;
   logic           super_q;
   logic [2:0]     sfc_q;
   logic [2:0]     dfc_q;
   logic [1:0]     excCode_q;
   logic [1:0]     lastExc_q;
   logic           instrReady_q;
   logic           doneOut_q;
   logic [1:0]     excOut_q;
   logic [31:0]    regRdata_q;

   // ------------------------------------------------------------
   // instruction decode
   // ------------------------------------------------------------
   wire [15:0] op         = instrIn.op;
   wire [15:0] ext        = instrIn.ext;
   wire [2:0]  mode       = op[5:3];
   wire [2:0]  rn         = op[2:0];
   wire [31:0] anVal      = gpr_q[{1'b1, rn}];
   wire        isQuick    = op[15:12] == `OPC_QUICK && !op[8];
   wire        isPeriph   = op[15:12] == `OPC_ZERO && op[8] && mode == `PER_MODE;
   wire        isSpace    = op[15:8] == `OPC_SPACE;
   wire        isMulti    = op[15:11] == `OPC_MULTI && op[9:7] == `MULTI_MID;
   wire        absOk      = mode == `EA_EXT && (rn == `EAX_ABSW || rn == `EAX_ABSL);
   wire        pcOk       = mode == `EA_EXT && (rn == `EAX_PCD || rn == `EAX_PCX);
   wire        ctrlAlt    = mode == `EA_IND || mode == `EA_DISP || mode == `EA_IDX || absOk;
   wire        multiLoad  = op[10];
   wire        multiOk    = multiLoad ? (ctrlAlt || pcOk || mode == `EA_POST)
                                      : (ctrlAlt || mode == `EA_PRE);
   wire        spaceOk    = op[7:6] != `SZ_BAD
                            && (ctrlAlt || mode == `EA_POST || mode == `EA_PRE);
   wire        knownOp    = isQuick || isPeriph || isSpace || isMulti;
   wire        badMode    = (isSpace && !spaceOk) || (isMulti && !multiOk) || !knownOp;
   // privilege is checked before the mode, so a user-state probe never leaks legality
   wire [1:0]  decodeExc  = (isSpace && !super_q) ? `EXC_PRIV
                          : (badMode ? `EXC_ILLEGAL : `EXC_NONE);
   wire        accept     = state_q == ST_IDLE && instrValid && instrReady_q;
   wire        quickWe    = accept && isQuick && decodeExc == `EXC_NONE;
   wire [31:0] quickVal   = {{24{op[7]}}, op[7:0]};
   // displacement, indexed and absolute forms arrive already resolved on instrIn.ea
   wire [31:0] baseAddr   = (mode >= `EA_DISP) ? instrIn.ea : anVal;
   wire [31:0] periphAddr = anVal + {{16{ext[15]}}, ext};
   wire [31:0] spaceLen   = op[7:6] == `SZ_BYTE ? `LEN_BYTE
                          : (op[7:6] == `SZ_WORD ? `LEN_WORD : `LEN_LONG);
   wire        stepMode   = mode == `EA_POST || mode == `EA_PRE;

   // ------------------------------------------------------------
   // transfer sequencing
   // ------------------------------------------------------------
   logic       maskAny;
   logic [3:0] maskIdx;

   first_set_finder #(.WIDTH(16), .IDX_W(4)) u_finder
   (
      .vec   (ctx_q.mask),
      .found (maskAny),
      .index (maskIdx)
   );

   wire [3:0]  multiReg   = ctx_q.pre ? ~maskIdx : maskIdx;
   wire        idleBus    = state_q == ST_BUS && !mem_q.req;
   wire        ackNow     = mem_q.req && memAck;
   wire        issueXfer  = ctx_q.kind == K_MULTI ? maskAny : ctx_q.cnt != 3'h0;
   wire        issueExtra = ctx_q.kind == K_MULTI && !maskAny
                            && !ctx_q.write && !ctx_q.extra;
   wire        finish     = idleBus && !issueXfer && !issueExtra;
   wire [3:0]  xferReg    = ctx_q.kind == K_MULTI ? multiReg : ctx_q.curReg;
   wire [31:0] xferVal    = gpr_q[xferReg];
   wire [31:0] busAddr    = ctx_q.pre ? ctx_q.addr - ctx_q.len : ctx_q.addr;
   wire [7:0]  perByte    = xferVal[{ctx_q.byteIdx, 3'h0} +: 8];
   wire [31:0] perWdata   = ctx_q.addr[0] ? {24'h0, perByte}
                                          : {16'h0, perByte, 8'h0};
   wire [2:0]  plainSpace = super_q ? SUPER_SPACE : USER_SPACE;
   wire [2:0]  xferSpace  = ctx_q.kind != K_SPACE ? plainSpace
                          : (ctx_q.write ? dfc_q : sfc_q);
   wire        readWe     = ackNow && !mem_q.write && !ctx_q.extra;

   // ------------------------------------------------------------
   // read data merge
   // ------------------------------------------------------------
   logic [31:0] rdVal;

   always_comb
   begin
      rdVal = gpr_q[ctx_q.curReg];
      unique case (ctx_q.kind)
         K_MULTI:
            rdVal = ctx_q.size == `SZ_LONG ? memRdata : {{16{memRdata[15]}}, memRdata[15:0]};
         K_PERIPH:
            rdVal[{ctx_q.byteIdx, 3'h0} +: 8] = ctx_q.addr[0] ? memRdata[7:0]
                                                               : memRdata[15:8];
         default:
         begin
            if (ctx_q.areg)
            begin
               unique case (ctx_q.size)
                  `SZ_BYTE: rdVal = {{24{memRdata[7]}}, memRdata[7:0]};
                  `SZ_WORD: rdVal = {{16{memRdata[15]}}, memRdata[15:0]};
                  default:  rdVal = memRdata;
               endcase
            end
            else
            begin
               unique case (ctx_q.size)
                  `SZ_BYTE: rdVal[7:0] = memRdata[7:0];
                  `SZ_WORD: rdVal[15:0] = memRdata[15:0];
                  default:  rdVal = memRdata;
               endcase
            end
         end
      endcase
   end

   // ------------------------------------------------------------
   // context and bus next values
   // ------------------------------------------------------------
   always_comb
   begin
      ctx_d = ctx_q;
      mem_d = mem_q;
      if (accept)
      begin
         ctx_d.extra  = 1'b0;
         ctx_d.wbReg  = {1'b1, rn};
         ctx_d.pre    = mode == `EA_PRE;
         ctx_d.wb     = stepMode;
         ctx_d.addr   = baseAddr;
         ctx_d.mask   = 16'h0000;
         ctx_d.areg   = 1'b0;
         if (isPeriph)
         begin
            ctx_d.kind    = K_PERIPH;
            ctx_d.write   = op[7];
            ctx_d.size    = `SZ_BYTE;
            ctx_d.len     = `PER_STEP;
            ctx_d.pre     = 1'b0;
            ctx_d.wb      = 1'b0;
            ctx_d.addr    = periphAddr;
            ctx_d.cnt     = op[6] ? `PER_CNT_LONG : `PER_CNT_WORD;
            ctx_d.byteIdx = op[6] ? `PER_TOP_LONG : `PER_TOP_WORD;
            ctx_d.curReg  = {1'b0, op[11:9]};
         end
         else if (isSpace)
         begin
            ctx_d.kind    = K_SPACE;
            ctx_d.write   = ext[11];
            ctx_d.size    = op[7:6];
            ctx_d.len     = spaceLen;
            ctx_d.cnt     = `SPACE_CNT;
            ctx_d.curReg  = {ext[15], ext[14:12]};
            ctx_d.areg    = ext[15];
         end
         else
         begin
            ctx_d.kind    = K_MULTI;
            ctx_d.write   = !multiLoad;
            ctx_d.size    = op[6] ? `SZ_LONG : `SZ_WORD;
            ctx_d.len     = op[6] ? `LEN_LONG : `LEN_WORD;
            ctx_d.mask    = ext;
            ctx_d.cnt     = 3'h0;
         end
      end
      if (ackNow)
      begin
         mem_d.req = 1'b0;
         if (!ctx_q.extra)
         begin
            ctx_d.addr    = ctx_q.pre ? ctx_q.addr - ctx_q.len
                                      : ctx_q.addr + ctx_q.len;
            ctx_d.cnt     = ctx_q.cnt == 3'h0 ? 3'h0 : ctx_q.cnt - 3'h1;
            ctx_d.byteIdx = ctx_q.byteIdx - 2'h1;
         end
      end
      else if (idleBus && (issueXfer || issueExtra))
      begin
         mem_d.req     = 1'b1;
         mem_d.write   = ctx_q.write && !issueExtra;
         mem_d.size    = ctx_q.size;
         mem_d.lowLane = ctx_q.addr[0];
         mem_d.space   = xferSpace;
         mem_d.addr    = busAddr;
         mem_d.wdata   = ctx_q.kind == K_PERIPH ? perWdata : xferVal;
         if (issueExtra)
            ctx_d.extra = 1'b1;
         if (ctx_q.kind == K_MULTI && maskAny)
         begin
            ctx_d.mask[maskIdx] = 1'b0;
            ctx_d.curReg        = multiReg;
         end
      end
   end

   // ------------------------------------------------------------
   // state machine
   // ------------------------------------------------------------
   always_comb
   begin
      state_d = state_q;
      unique case (state_q)
         ST_IDLE:
            if (accept)
               state_d = decodeExc != `EXC_NONE ? ST_TRAP : (isQuick ? ST_DONE : ST_BUS);
         ST_BUS:
            if (finish)
               state_d = ST_DONE;
         ST_DONE:
            state_d = ST_IDLE;
         ST_TRAP:
            state_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state_q <= ST_IDLE;
         ctx_q   <= '0;
         mem_q   <= '0;
      end
      else
      begin
         state_q <= state_d;
         ctx_q   <= ctx_d;
         mem_q   <= mem_d;
      end
   end

   // ------------------------------------------------------------
   // register file
   // ------------------------------------------------------------
   // hardware writes beat a same-cycle software write to the same file
   wire        gprWe    = quickWe || readWe || (finish && ctx_q.wb);
   wire [3:0]  gprWaddr = quickWe ? {1'b0, op[11:9]} : (readWe ? ctx_q.curReg : ctx_q.wbReg);
   wire [31:0] gprWdata = quickWe ? quickVal : (readWe ? rdVal : ctx_q.addr);
   wire        swGprWe  = regWr && !regAddr[4];

   always_ff @(posedge clk)
   begin
      if (gprWe)
         gpr_q[gprWaddr] <= gprWdata;
      else if (swGprWe)
         gpr_q[regAddr[3:0]] <= regWdata;
   end

   wire swCtrl = regWr && regAddr == `REG_CTRL;

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         ccr_q   <= '0;
         super_q <= `SUPER_RESET;
         sfc_q   <= `SPACE_RESET;
         dfc_q   <= `SPACE_RESET;
      end
      else
      begin
         if (quickWe)
            ccr_q <= '{x: ccr_q.x, n: quickVal[31], z: quickVal == 32'h0,
                       v: 1'b0, c: 1'b0};
         else if (swCtrl)
            ccr_q <= regWdata[`CCR_MSB:0];
         if (swCtrl)
            super_q <= regWdata[`CTRL_SUPER];
         if (regWr && regAddr == `REG_SFC)
            sfc_q <= regWdata[2:0];
         if (regWr && regAddr == `REG_DFC)
            dfc_q <= regWdata[2:0];
      end
   end

   // ------------------------------------------------------------
   // register port read and outputs
   // ------------------------------------------------------------
   logic [31:0] ctrlWord;
   logic [31:0] statWord;
   logic [31:0] rdSel;

   always_comb
   begin
      ctrlWord                = '0;
      ctrlWord[`CTRL_SUPER]   = super_q;
      ctrlWord[`CCR_MSB:0]    = ccr_q;
      statWord                = '0;
      statWord[`STAT_BUSY]    = state_q != ST_IDLE;
      statWord[`STAT_EXC_LSB +: 2] = lastExc_q;
      unique case (regAddr)
         `REG_CTRL: rdSel = ctrlWord;
         `REG_SFC:  rdSel = {29'h0, sfc_q};
         `REG_DFC:  rdSel = {29'h0, dfc_q};
         `REG_STAT: rdSel = statWord;
         default:   rdSel = regAddr[4] ? 32'h0 : gpr_q[regAddr[3:0]];
      endcase
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         excCode_q    <= `EXC_NONE;
         lastExc_q    <= `EXC_NONE;
         instrReady_q <= 1'b0;
         doneOut_q    <= 1'b0;
         excOut_q     <= `EXC_NONE;
         regRdata_q   <= 32'h0;
      end
      else
      begin
         if (accept)
            excCode_q <= decodeExc;
         if (state_q == ST_TRAP)
            lastExc_q <= excCode_q;
         instrReady_q <= state_d == ST_IDLE;
         doneOut_q    <= state_q == ST_DONE;
         excOut_q     <= state_q == ST_TRAP ? excCode_q : `EXC_NONE;
         regRdata_q   <= regRd ? rdSel : 32'h0;
      end
   end

   assign instrReady = instrReady_q;
   assign doneOut    = doneOut_q;
   assign excOut     = excOut_q;
   assign regRdata   = regRdata_q;
   assign memOut     = mem_q;

endmodule

// *** testbench/mem_model.sv ***
// memory partner with adjustable acknowledge delay
`timescale 1ns/10ps
module mem_model
(
   // clock and reset
   input  wire logic                       clk,
   input  wire logic                       nrst,
   // bus from the executor
   input  wire move_exec_pkg::mem_req_type memOut,
   input  wire logic [1:0]                 delay,
   output logic                            memAck,
   output logic [31:0]                     memRdata
);
   import move_exec_pkg::*;
   logic [1:0]  wait_q;
   logic [31:0] hold_q;
   logic [31:0] lastAddr = 32'h0;
   logic [31:0] lastData = 32'h0;
   logic [2:0]  lastSpace = 3'h0;
   int          nRead = 0;
   assign memAck = memOut.req && wait_q == delay;
   // read data carries the low address byte on every lane
   // off-ack cycles toggle so a stale sample is caught
   assign memRdata = memAck ? {4{memOut.addr[7:0]}} : ~hold_q;
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         wait_q <= 2'h0;
         hold_q <= 32'h0;
      end
      else
      begin
         wait_q <= (memAck || !memOut.req) ? 2'h0 : wait_q + 2'h1;
         hold_q <= memRdata;
      end
   end
   always @(posedge clk)
   begin
      if (memAck)
      begin
         lastAddr = memOut.addr;
         lastData = memOut.wdata;
         lastSpace = memOut.space;
         nRead = nRead + (memOut.write ? 0 : 1);
      end
   end
endmodule

// *** testbench/move_group_exec_assertions.sv ***
// property checker for the move group executor
`timescale 1ns/10ps
`include "move_exec_cfg.svh"
module move_group_exec_assertions
(
   // clock and reset
   input wire logic                       clk,
   input wire logic                       nrst,
   // instruction hand-off
   input wire logic                       instrValid,
   input wire move_exec_pkg::instr_type   instrIn,
   input wire logic                       instrReady,
   input wire logic                       doneOut,
   input wire logic [1:0]                 excOut,
   // register writes and memory bus
   input wire logic [4:0]                 regAddr,
   input wire logic [31:0]                regWdata,
   input wire logic                       regWr,
   input wire move_exec_pkg::mem_req_type memOut,
   input wire logic                       memAck
);
   import move_exec_pkg::*;
   logic [15:0] op;
   logic        acc;
   logic        isQ;
   logic        isP;
   logic        isS;
   logic        hit;
   logic [1:0]  kind_q;
   logic [1:0]  size_q;
   logic        seen_q;
   logic [31:0] last_q;
   logic [2:0]  sfc_q;
   logic [2:0]  dfc_q;
   assign op  = instrIn.op;
   assign acc = instrValid & instrReady;
   assign isQ = op[15:12] == `OPC_QUICK && !op[8];
   assign isP = op[15:12] == `OPC_ZERO && op[8] && op[5:3] == `PER_MODE;
   assign isS = op[15:8] == `OPC_SPACE;
   assign hit = memOut.req & memAck;
   // space codes shadowed from port writes, the only way they change
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         kind_q <= 2'h0;
         size_q <= 2'h0;
         seen_q <= 1'b0;
         last_q <= 32'h0;
         sfc_q  <= `SPACE_RESET;
         dfc_q  <= `SPACE_RESET;
      end
      else
      begin
         kind_q <= acc ? {isS, isP} : ((doneOut || excOut != 2'h0) ? 2'h0 : kind_q);
         size_q <= acc ? op[7:6] : size_q;
         seen_q <= acc ? 1'b0 : (seen_q | hit);
         last_q <= hit ? memOut.addr : last_q;
         sfc_q  <= (regWr && regAddr == `REG_SFC) ? regWdata[2:0] : sfc_q;
         dfc_q  <= (regWr && regAddr == `REG_DFC) ? regWdata[2:0] : dfc_q;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   property p_quick; acc && isQ |-> ##2 doneOut && excOut == `EXC_NONE; endproperty
   property p_qbus; acc && isQ |=> !memOut.req [*2]; endproperty
   property p_lane;
      kind_q == 2'h1 && memOut.req |-> memOut.lowLane == memOut.addr[0] && memOut.size == `SZ_BYTE;
   endproperty
   property p_step; kind_q == 2'h1 && memOut.req && seen_q |-> memOut.addr == last_q + `PER_STEP;
   endproperty
   property p_space;
      kind_q == 2'h2 && memOut.req |-> memOut.space == (memOut.write ? dfc_q : sfc_q);
   endproperty
   property p_size; kind_q == 2'h2 && memOut.req |-> memOut.size == size_q; endproperty
   property p_spbad; acc && isS && op[5:3] < `EA_IND |-> ##2 excOut != `EXC_NONE; endproperty
   property p_nobus; acc && isS && op[5:3] < `EA_IND |=> !memOut.req [*2]; endproperty
   property p_mbad;
      acc && op[15:11] == `OPC_MULTI && op[10] && op[5:3] == `EA_PRE |-> ##2 excOut == `EXC_ILLEGAL;
   endproperty
   a_quick: assert property (p_quick)
      else $error("quick load did not complete");
   a_qbus: assert property (p_qbus)
      else $error("quick load used the bus");
   a_lane: assert property (p_lane)
      else $error("peripheral byte on wrong lane");
   a_step: assert property (p_step)
      else $error("peripheral address step wrong");
   a_space: assert property (p_space)
      else $error("space move used wrong space code");
   a_size: assert property (p_size)
      else $error("space move size wrong");
   a_spbad: assert property (p_spbad)
      else $error("bad space mode not refused");
   a_nobus: assert property (p_nobus)
      else $error("refused move touched the bus");
   a_mbad: assert property (p_mbad)
      else $error("bad multi load mode not refused");
   c_quick: cover property (acc && isQ);
   c_per: cover property (kind_q == 2'h1 && hit);
   c_trap: cover property (excOut == `EXC_PRIV);
endmodule

// *** testbench/move_group_instruction_exec_test.sv ***
// testbench for the move group executor
`timescale 1ns/10ps
`include "move_exec_cfg.svh"
`define CHK(nm, e, g) begin nTests++; if ((g) !== (e)) begin miscompares++; \
   $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module move_group_instruction_exec_test;
   import move_exec_pkg::*;
   logic        clk = 1'b0;
   logic        nrst = 1'b0;
   logic        instrValid = 1'b0;
   instr_type   instrIn = '0;
   logic [4:0]  regAddr = 5'h00;
   logic [31:0] regWdata = 32'h0;
   logic        regWr = 1'b0;
   logic        regRd = 1'b0;
   logic [1:0]  dly = 2'h0;
   logic        instrReady;
   logic        doneOut;
   logic [1:0]  excOut;
   logic [31:0] regRdata;
   mem_req_type memOut;
   logic        memAck;
   logic [31:0] memRdata;
   int          miscompares = 0;
   int          nTests = 0;
   int          n0;
   move_group_exec uut (.clk(clk), .nrst(nrst), .instrValid(instrValid), .instrIn(instrIn),
      .instrReady(instrReady), .doneOut(doneOut), .excOut(excOut), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
      .memOut(memOut), .memAck(memAck), .memRdata(memRdata));
   mem_model mem (.clk(clk), .nrst(nrst), .memOut(memOut), .delay(dly), .memAck(memAck),
      .memRdata(memRdata));
   always #5 clk = ~clk;
   // ------
   // bus helpers
   // ------
   task automatic conclude();
      if (miscompares == 0 && nTests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      @(posedge clk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
   endtask
   task automatic chkReg(input logic [4:0] a, input logic [31:0] e);
      @(posedge clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      #1;
      `CHK("register", e, regRdata)
   endtask
   task automatic run(input logic [15:0] op, input logic [15:0] ext, input logic [1:0] e);
      int i;
      @(posedge clk);
      instrIn <= '{op: op, ext: ext, ea: 32'h0};
      instrValid <= 1'b1;
      @(posedge clk);
      instrValid <= 1'b0;
      for (i = 0; i < 60; i++)
      begin
         #1;
         if (doneOut === 1'b1 || excOut !== `EXC_NONE)
            break;
         @(posedge clk);
      end
      `CHK("exception", e, excOut)
      if (i == 60)
      begin
         miscompares++;
         conclude();
      end
   endtask
   // ------
   // scenarios
   // ------
   task automatic tQuick();
      wr(`REG_CTRL, 32'h2013);
      run(16'h7680, 16'h0, `EXC_NONE);
      chkReg(5'h03, 32'hFFFFFF80);
      chkReg(`REG_CTRL, 32'h2018);
      run(16'h7600, 16'h0, `EXC_NONE);
      chkReg(5'h03, 32'h0);
      chkReg(`REG_CTRL, 32'h2014);
   endtask
   task automatic tPeriph();
      dly <= 2'h2;
      wr(5'h09, 32'h120);
      run(16'h0549, 16'hFFF1, `EXC_NONE);
      chkReg(5'h02, 32'h11131517);
      run(16'h0589, 16'hFFF0, `EXC_NONE);
      `CHK("address", 32'h112, mem.lastAddr)
      `CHK("data", 8'h17, mem.lastData[15:8])
      dly <= 2'h0;
   endtask
   task automatic tMulti();
      wr(5'h08, 32'h40);
      n0 = mem.nRead;
      run(16'h4C98, 16'h0005, `EXC_NONE);
      chkReg(5'h00, 32'h4040);
      chkReg(5'h02, 32'h4242);
      chkReg(5'h08, 32'h44);
      `CHK("reads", 3, mem.nRead - n0)
      wr(5'h0F, 32'h1234);
      wr(5'h08, 32'h80);
      run(16'h48A0, 16'h8001, `EXC_NONE);
      `CHK("address", 32'h7C, mem.lastAddr)
      `CHK("data", 16'h4040, mem.lastData[15:0])
      n0 = mem.nRead;
      run(16'h4CA0, 16'h0001, `EXC_ILLEGAL);
      `CHK("reads", 0, mem.nRead - n0)
   endtask
   task automatic tSpace();
      wr(`REG_CTRL, 32'h0);
      run(16'h0E10, 16'h1000, `EXC_PRIV);
      wr(`REG_CTRL, 32'h2000);
      wr(`REG_SFC, 32'h3);
      wr(`REG_DFC, 32'h5);
      wr(5'h01, 32'h12345678);
      run(16'h0E10, 16'h1000, `EXC_NONE);
      chkReg(5'h01, 32'h1234567C);
      `CHK("space", 3'h3, mem.lastSpace)
      run(16'h0E90, 16'h1800, `EXC_NONE);
      `CHK("space", 3'h5, mem.lastSpace)
      `CHK("data", 32'h1234567C, mem.lastData)
      run(16'h0E00, 16'h1000, `EXC_ILLEGAL);
   endtask
   initial
   begin
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      repeat (2) @(posedge clk);
      tQuick();
      tPeriph();
      tMulti();
      tSpace();
      conclude();
   end
endmodule
bind move_group_exec move_group_exec_assertions chk (.clk(clk), .nrst(nrst),
   .instrValid(instrValid), .instrIn(instrIn), .instrReady(instrReady), .doneOut(doneOut),
   .excOut(excOut), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
   .memOut(memOut), .memAck(memAck));
